// *** rtl/rlnc_consts.svh ***
// constants for the rotate-left-no-carry execution datapath
`ifndef RLNC_CONSTS_SVH
`define RLNC_CONSTS_SVH
`define RLNC_OPCODE        6'h11
`define RLNC_IDX_LIMIT     8'h5F
`define RLNC_ACC_SPLIT     8'h60
`define RLNC_ACC_HIGH_BANK 4'hF
`define RLNC_ACC_LOW_BANK  4'h0
`define RLNC_RST_BYTE      8'h00
`define RLNC_RST_ADDR      12'h000
`define RLNC_RST_BANK      4'h0
`define RLNC_MSB           7
`define RLNC_OP_HI         15
`define RLNC_OP_LO         10
`define RLNC_D_BIT         9
`define RLNC_A_BIT         8
`define RLNC_F_HI          7
`define RLNC_F_LO          0
`endif

// *** rtl/rlnc_pkg.sv ***
// types for the rotate-left-no-carry execution datapath
package rlnc_pkg;
    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } rlnc_phase_t;
endpackage : rlnc_pkg

// *** rtl/rlnc_addr_resolve.sv ***
// operand address resolver: access bank, banked and indexed modes
`timescale 1ns/1ps
`default_nettype none
`include "rlnc_consts.svh"
module rlnc_addr_resolve
    import rlnc_pkg::*;
(
    input  wire logic [7:0]  fileAddr,
    input  wire logic        accessSel,
    input  wire logic        extEnable,
    input  wire logic [3:0]  bankSelectReg,
    input  wire logic [11:0] indexBase,
    output logic      [11:0] ramAddr,
    output logic             indexedMode
);
    always_comb begin
        indexedMode = 1'b0;
        if (accessSel) begin
            ramAddr = {bankSelectReg, fileAddr};
        end else if (extEnable && (fileAddr <= `RLNC_IDX_LIMIT)) begin
            indexedMode = 1'b1;
            ramAddr = 12'(indexBase + {4'h0, fileAddr});
        end else if (fileAddr < `RLNC_ACC_SPLIT) begin
            ramAddr = {`RLNC_ACC_LOW_BANK, fileAddr};
        end else begin
            ramAddr = {`RLNC_ACC_HIGH_BANK, fileAddr};
        end
    end
endmodule : rlnc_addr_resolve
`default_nettype wire

// *** rtl/rlnc_exec.sv ***
// execution unit for the rotate-left-no-carry instruction
`timescale 1ns/1ps
`default_nettype none
`include "rlnc_consts.svh"
module rlnc_exec
    import rlnc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        instrValid,
    input  wire logic [15:0] instrWord,
    input  wire logic        extEnable,
    input  wire logic [3:0]  bankSelectReg,
    input  wire logic [11:0] indexBase,
    input  wire logic [7:0]  ramRdData,
    output logic      [11:0] ramAddr_ff,
    output logic             ramRdEn_ff,
    output logic             ramWrEn_ff,
    output logic      [7:0]  ramWrData_ff,
    output logic      [7:0]  wregData_ff,
    output logic             wregWrEn_ff,
    output logic             flagWrEn_ff,
    output logic             flagNeg_ff,
    output logic             flagZero_ff,
    output logic             busy_ff,
    output logic             done_ff,
    output logic             indexed_ff
);
    // ****************************************
    // helpers
    // ****************************************
    // the msb wraps into bit 0; carry plays no part
    function automatic logic [7:0] rotLeft(input logic [7:0] v);
        rotLeft = {v[`RLNC_MSB-1:0], v[`RLNC_MSB]};
    endfunction : rotLeft

    // zero test for the Z flag; an all-zero byte equals the reset byte
    function automatic logic isZero(input logic [7:0] v);
        isZero = (v == `RLNC_RST_BYTE);
    endfunction : isZero

    rlnc_phase_t phase_ff;
    logic        destSel_ff;
    logic [7:0]  result_ff;
    logic [11:0] resAddr;
    logic        resIdx;
    logic        accept;
    logic        writePhase;
    logic [5:0]  opField;
    logic [7:0]  fileField;
    logic        accessField;
    logic        destField;

    // ****************************************
    // instruction field decode
    // ****************************************
    // fields are split once so resolver and latches see the same bits
    assign opField     = instrWord[`RLNC_OP_HI:`RLNC_OP_LO];
    assign destField   = instrWord[`RLNC_D_BIT];
    assign accessField = instrWord[`RLNC_A_BIT];
    assign fileField   = instrWord[`RLNC_F_HI:`RLNC_F_LO];

    // words offered while busy are dropped, not queued: the core never overlaps
    // the opcode compare uses all six bits; no neighbour shares this decoder
    assign accept = instrValid && !busy_ff && (opField == `RLNC_OPCODE);
    // the write phase drives every strobe below except the read strobe
    assign writePhase = (phase_ff == PH_WRITE);

    rlnc_addr_resolve uResolve (
        .fileAddr      (fileField),
        .accessSel     (accessField),
        .extEnable     (extEnable),
        .bankSelectReg (bankSelectReg),
        .indexBase     (indexBase),
        .ramAddr       (resAddr),
        .indexedMode   (resIdx)
    );

    // ****************************************
    // phase sequencer
    // ****************************************
    // one instruction per four-phase cycle
    // default is unreachable with four states; it only guards a corrupted code
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase_ff <= PH_DECODE;
        end else begin
            case (phase_ff)
                PH_DECODE: begin
                    if (accept) begin
                        phase_ff <= PH_READ;
                    end
                end
                PH_READ: begin
                    phase_ff <= PH_PROCESS;
                end
                PH_PROCESS: begin
                    phase_ff <= PH_WRITE;
                end
                PH_WRITE: begin
                    phase_ff <= PH_DECODE;
                end
                default: begin
                    phase_ff <= PH_DECODE;
                end
            endcase
        end
    end

    // busy spans read, process and write; it falls as the write strobes rise
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
        end else if (accept) begin
            busy_ff <= 1'b1;
        end else if (writePhase) begin
            busy_ff <= 1'b0;
        end
    end

    // ****************************************
    // operand address and data
    // ****************************************
    // address is frozen at accept, so later bank or index changes cannot leak in
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ramAddr_ff <= `RLNC_RST_ADDR;
        end else if (accept) begin
            ramAddr_ff <= resAddr;
        end
    end

    // reset picks memory, the destination of the short operand form
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            destSel_ff <= 1'b1;
        end else if (accept) begin
            destSel_ff <= destField;
        end
    end

    // tells the core the operand came from the indexed window
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            indexed_ff <= 1'b0;
        end else if (accept) begin
            indexed_ff <= resIdx;
        end
    end

    // the strobe leaves with the latched address, in the read phase
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ramRdEn_ff <= 1'b0;
        end else begin
            ramRdEn_ff <= accept;
        end
    end

    // read data sampled in the process phase, one cycle after the read strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            result_ff <= `RLNC_RST_BYTE;
        end else if (phase_ff == PH_PROCESS) begin
            result_ff <= rotLeft(ramRdData);
        end
    end

    // ****************************************
    // result write
    // ****************************************
    // one destination strobe per instruction, never both
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ramWrEn_ff   <= 1'b0;
            ramWrData_ff <= `RLNC_RST_BYTE;
        end else begin
            ramWrEn_ff <= 1'b0;
            if (writePhase && destSel_ff) begin
                ramWrEn_ff   <= 1'b1;
                ramWrData_ff <= result_ff;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wregWrEn_ff <= 1'b0;
            wregData_ff <= `RLNC_RST_BYTE;
        end else begin
            wregWrEn_ff <= 1'b0;
            if (writePhase && !destSel_ff) begin
                wregWrEn_ff <= 1'b1;
                wregData_ff <= result_ff;
            end
        end
    end

    // ****************************************
    // status flags and completion
    // ****************************************
    // carry is never touched: there is no carry output, so the core keeps its carry
    // N and Z follow the rotated byte whichever destination is chosen
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flagWrEn_ff <= 1'b0;
            flagNeg_ff  <= 1'b0;
            flagZero_ff <= 1'b0;
        end else begin
            flagWrEn_ff <= 1'b0;
            if (writePhase) begin
                flagWrEn_ff <= 1'b1;
                flagNeg_ff  <= result_ff[`RLNC_MSB];
                flagZero_ff <= isZero(result_ff);
            end
        end
    end

    // done marks the cycle in which the destination is updated
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= writePhase;
        end
    end
endmodule : rlnc_exec
`default_nettype wire

// *** tb/rlnc_exec_properties.sv ***
// port-level checks for the rotate-left-no-carry unit
`timescale 1ns/1ps
`default_nettype none
module rlnc_exec_properties (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        instrValid,
    input wire logic        extEnable,
    input wire logic [15:0] instrWord,
    input wire logic [3:0]  bankSelectReg,
    input wire logic [11:0] indexBase,
    input wire logic [11:0] ramAddr_ff,
    input wire logic [7:0]  ramRdData,
    input wire logic [7:0]  ramWrData_ff,
    input wire logic [7:0]  wregData_ff,
    input wire logic        ramRdEn_ff,
    input wire logic        ramWrEn_ff,
    input wire logic        wregWrEn_ff,
    input wire logic        flagWrEn_ff,
    input wire logic        flagNeg_ff,
    input wire logic        flagZero_ff,
    input wire logic        busy_ff,
    input wire logic        done_ff,
    input wire logic        indexed_ff
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire acc = instrValid && !busy_ff && instrWord[15:10] == 6'h11;
    wire [7:0] f = instrWord[7:0];
    wire [7:0] res = ramWrEn_ff ? ramWrData_ff : wregData_ff;
    logic [7:0] rdLast;
    always_ff @(posedge clock) rdLast <= ramRdData;
    AST_READ: assert property (acc |=> ramRdEn_ff && busy_ff)
        else $error("no read");
    AST_DONE: assert property (acc |-> ##4 done_ff && !busy_ff && flagWrEn_ff)
        else $error("late end");
    AST_TO_W: assert property (acc && !instrWord[9] |-> ##4 wregWrEn_ff && !ramWrEn_ff)
        else $error("bad w dest");
    AST_TO_F: assert property (acc && instrWord[9] |-> ##4 ramWrEn_ff && !wregWrEn_ff)
        else $error("bad f dest");
    AST_ROT: assert property (ramRdEn_ff |-> ##3 res == {rdLast[6:0], rdLast[7]})
        else $error("bad rotate");
    AST_FLAGS: assert property (flagWrEn_ff |-> flagNeg_ff == res[7] && flagZero_ff == (res == 0))
        else $error("bad flags");
    AST_BANK: assert property (acc && instrWord[8] |=> ramAddr_ff == {$past(bankSelectReg), $past(f)})
        else $error("bad bank addr");
    AST_ACCESS: assert property (acc && !instrWord[8] && !(extEnable && f <= 8'h5F)
        |=> ramAddr_ff == {{4{$past(f) > 8'h5F}}, $past(f)} && !indexed_ff)
        else $error("bad access addr");
    AST_INDEX: assert property (acc && !instrWord[8] && extEnable && f <= 8'h5F
        |=> indexed_ff && ramAddr_ff == $past(indexBase) + {4'h0, $past(f)})
        else $error("bad indexed addr");
    cover property (acc && instrWord[9]);
    cover property (acc && !instrWord[9]);
    cover property (indexed_ff && done_ff);
endmodule : rlnc_exec_properties
bind rlnc_exec rlnc_exec_properties u_props (
    .clock         (clock),
    .rst_n         (rst_n),
    .instrValid    (instrValid),
    .extEnable     (extEnable),
    .instrWord     (instrWord),
    .bankSelectReg (bankSelectReg),
    .indexBase     (indexBase),
    .ramAddr_ff    (ramAddr_ff),
    .ramRdData     (ramRdData),
    .ramWrData_ff  (ramWrData_ff),
    .wregData_ff   (wregData_ff),
    .ramRdEn_ff    (ramRdEn_ff),
    .ramWrEn_ff    (ramWrEn_ff),
    .wregWrEn_ff   (wregWrEn_ff),
    .flagWrEn_ff   (flagWrEn_ff),
    .flagNeg_ff    (flagNeg_ff),
    .flagZero_ff   (flagZero_ff),
    .busy_ff       (busy_ff),
    .done_ff       (done_ff),
    .indexed_ff    (indexed_ff)
);
`default_nettype wire

// *** tb/rlnc_ram_model.sv ***
// data memory stand-in on the unit's memory port
`timescale 1ns/1ps
`default_nettype none
module rlnc_ram_model (
    input  wire logic        clock,
    input  wire logic [11:0] ramAddr_ff,
    input  wire logic        ramRdEn_ff,
    input  wire logic        ramWrEn_ff,
    input  wire logic [7:0]  ramWrData_ff,
    output var  logic [7:0]  ramRdData
);
    logic [7:0] mem [4096];
    logic       keep   = 1'b0;
    logic [7:0] rdByte = 8'h5A;
    assign ramRdData = rdByte;
    // past the hold time the bus flips, so a late sample cannot pass by luck
    always @(posedge clock) begin
        if (ramWrEn_ff) mem[ramAddr_ff] <= ramWrData_ff;
        keep <= ramRdEn_ff;
        if (ramRdEn_ff) rdByte <= mem[ramAddr_ff];
        else if (!keep) rdByte <= ~rdByte;
    end
endmodule : rlnc_ram_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the rotate-left-no-carry unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 0, rst_n = 0, instrValid = 0, extEnable = 0;
    logic [15:0] instrWord = '0;
    logic [3:0] bankSelectReg = '0;
    logic [11:0] indexBase = '0, ramAddr_ff;
    logic [7:0] ramRdData, ramWrData_ff, wregData_ff;
    logic ramRdEn_ff, ramWrEn_ff, wregWrEn_ff, flagWrEn_ff, flagNeg_ff, flagZero_ff;
    logic busy_ff, done_ff, indexed_ff;
    int mismatches = 0, samples_checked = 0;
    always #12.5 clock = ~clock;
    rlnc_exec dut (
        .clock         (clock),
        .rst_n         (rst_n),
        .instrValid    (instrValid),
        .instrWord     (instrWord),
        .extEnable     (extEnable),
        .bankSelectReg (bankSelectReg),
        .indexBase     (indexBase),
        .ramRdData     (ramRdData),
        .ramAddr_ff    (ramAddr_ff),
        .ramRdEn_ff    (ramRdEn_ff),
        .ramWrEn_ff    (ramWrEn_ff),
        .ramWrData_ff  (ramWrData_ff),
        .wregData_ff   (wregData_ff),
        .wregWrEn_ff   (wregWrEn_ff),
        .flagWrEn_ff   (flagWrEn_ff),
        .flagNeg_ff    (flagNeg_ff),
        .flagZero_ff   (flagZero_ff),
        .busy_ff       (busy_ff),
        .done_ff       (done_ff),
        .indexed_ff    (indexed_ff)
    );
    rlnc_ram_model ram (
        .clock        (clock),
        .ramAddr_ff   (ramAddr_ff),
        .ramRdEn_ff   (ramRdEn_ff),
        .ramWrEn_ff   (ramWrEn_ff),
        .ramWrData_ff (ramWrData_ff),
        .ramRdData    (ramRdData)
    );
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [11:0] ex, input logic [11:0] got);
        samples_checked++;
        if (got !== ex) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic run(input logic [15:0] w, input logic [7:0] v);
        logic [7:0] f, r;
        logic [11:0] ea;
        int n;
        f = w[7:0];
        r = {v[6:0], v[7]};
        ea = w[8] ? {bankSelectReg, f} : (extEnable && f <= 8'h5F) ? indexBase + {4'h0, f}
            : {(f > 8'h5F) ? 4'hF : 4'h0, f};
        ram.mem[ea] = v;
        @(negedge clock);
        instrValid = 1;
        instrWord = w;
        // held high while busy: the repeats must be ignored
        repeat (3) @(negedge clock);
        instrValid = 0;
        for (n = 0; n < 9 && done_ff !== 1; n++) @(negedge clock);
        if (n == 9) begin
            mismatches++;
            wrap_up();
        end
        chk("addr", ea, ramAddr_ff);
        chk("idx", {11'h0, !w[8] && extEnable && f <= 8'h5F}, {11'h0, indexed_ff});
        chk("dest", w[9] ? 12'h1 : 12'h2, {10'h0, wregWrEn_ff, ramWrEn_ff});
        chk("res", {4'h0, r}, {4'h0, w[9] ? ramWrData_ff : wregData_ff});
        chk("flags", {9'h1, r[7], r == 0}, {9'h0, flagWrEn_ff, flagNeg_ff, flagZero_ff});
        @(negedge clock);
        chk("stored", {4'h0, w[9] ? r : v}, {4'h0, ram.mem[ea]});
    endtask : run
    initial begin
        void'($urandom(32'h1CDA));
        repeat (3) @(negedge clock);
        rst_n = 1;
        run(16'h4625, 8'hAB);
        run(16'h45F0, 8'h00);
        instrWord = 16'h4225;
        instrValid = 1;
        @(negedge clock);
        instrValid = 0;
        @(negedge clock);
        chk("busy", 12'h0, {11'h0, busy_ff});
        // reset in mid-flight must abandon the instruction without a write
        instrWord = 16'h4625;
        instrValid = 1;
        @(negedge clock);
        rst_n = 0;
        instrValid = 0;
        @(negedge clock);
        chk("rstRead", 12'h0, {10'h0, busy_ff, ramRdEn_ff});
        rst_n = 1;
        repeat (5) begin
            @(negedge clock);
            chk("rstDone", 12'h0, {10'h0, done_ff, ramWrEn_ff});
        end
        extEnable = 1;
        indexBase = 12'h3F0;
        run(16'h4410, 8'h81);
        run(16'h46A0, 8'h80);
        repeat (40) begin
            extEnable = 1'($urandom);
            bankSelectReg = 4'($urandom);
            indexBase = 12'($urandom);
            run({6'h11, 10'($urandom)}, 8'($urandom));
        end
        wrap_up();
    end
endmodule : tb
`default_nettype wire
